// ### rtl/seep_pkg.sv
// Constants, types and helpers shared by the serial EEPROM slave
package seep_pkg;

  // ==========================================================
  // Storage array and buffering
  localparam int ARR_DEPTH   = 2048;
  localparam int ARR_ADDR_W  = 11;
  localparam int DATA_W      = 8;
  localparam int FIFO_DEPTH  = 8;

  // ==========================================================
  // Select byte layout, MSB first
  localparam int SEL_TYPE_MSB = 7;
  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_HI_MSB   = 3;
  localparam int SEL_HI_LSB   = 1;
  localparam int SEL_RW_BIT   = 0;
  // Device type identifier, value arbitrary
  localparam logic [3:0] TYPE_ID_DEFAULT = 4'h5;
  localparam logic [2:0] BIT_LAST        = 3'h7;

  // ==========================================================
  // Timing: internal write cycle
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_WRITE_MS    = 5;
  localparam int WRITE_CYC     = T_WRITE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TIMER_W       = 20;

  // ==========================================================
  // Software register port
  localparam int              REG_ADDR_W     = 4;
  localparam int              REG_DATA_W     = 8;
  localparam logic [3:0]      REG_STATUS_OFS = 4'h0;
  localparam logic [3:0]      REG_CTRL_OFS   = 4'h1;
  localparam logic [7:0]      CTRL_RESET     = 8'h01;
  localparam int              CTRL_EN_BIT    = 0;
  localparam int              STAT_BUSY_BIT  = 3;
  localparam int              STAT_WP_BIT    = 4;

  // ==========================================================
  // Serial interface states, Gray along idle-rx-ack-tx-rack
  typedef enum logic [2:0] {
    SEEP_IDLE  = 3'h0,
    SEEP_RX    = 3'h1,
    SEEP_ACK   = 3'h3,
    SEEP_TX    = 3'h2,
    SEEP_RACK  = 3'h6,
    SEEP_WAIT  = 3'h7,
    SEEP_WRITE = 3'h5
  } seep_state_t;

  // Which byte of a transfer is being received
  typedef enum logic [1:0] {
    SEEP_PH_SEL  = 2'h0,
    SEEP_PH_ADDR = 2'h1,
    SEEP_PH_DATA = 2'h3
  } seep_phase_t;

  // Next address inside the same 16-byte page
  function automatic logic [ARR_ADDR_W-1:0] seep_page_inc(input logic [ARR_ADDR_W-1:0] a);
    seep_page_inc = {a[ARR_ADDR_W-1:4], 4'(a[3:0] + 4'h1)};
  endfunction

endpackage

// ### rtl/seep_fifo_if.sv
// Interface carrying the write-data buffer handshakes
`timescale 1ns/100ps
interface seep_fifo_if #(parameter int WIDTH = 8);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;
  logic             flush;

  // Block side fills and drains
  modport user  (output push_valid, push_data, pop_ready, flush,
                 input  push_ready, pop_valid, pop_data);
  // Buffer side
  modport store (input  push_valid, push_data, pop_ready, flush,
                 output push_ready, pop_valid, pop_data);
endinterface

// ### rtl/seep_pin_sync.sv
// Two-flop synchronisers for pin inputs
`timescale 1ns/100ps
module seep_pin_sync #(
  parameter int N = 3
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  // Pins and synchronised copies
  input  wire logic [N-1:0] async_in,
  output logic      [N-1:0] sync_out
);

  // ==========================================================
  // One chain per pin
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_sync
      logic meta;
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta        <= 1'b1;
          sync_out[i] <= 1'b1;
        end else begin
          meta        <= async_in[i];
          sync_out[i] <= meta;
        end
      end
    end
  endgenerate

endmodule // seep_pin_sync

// ### rtl/seep_fifo.sv
// Write-data buffer between byte receiver and array
`timescale 1ns/100ps
module seep_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Handshakes
  seep_fifo_if.store fifo
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store_mem [0:DEPTH-1];
  logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CNT_W-1:0] count, next_count;
  logic             do_push, do_pop;

  // ==========================================================
  // Flags and pointer updates
  always_comb begin
    fifo.push_ready = (count != CNT_W'(DEPTH));
    fifo.pop_valid  = (count != '0);
    fifo.pop_data   = store_mem[rd_ptr];
    do_push         = fifo.push_valid & fifo.push_ready;
    do_pop          = fifo.pop_valid & fifo.pop_ready;
    next_wr_ptr     = do_push ? PTR_W'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr     = do_pop ? PTR_W'(rd_ptr + 1'b1) : rd_ptr;
    next_count      = CNT_W'(count + CNT_W'(do_push) - CNT_W'(do_pop));
    if (fifo.flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
  end

  // Pointer registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage, no reset
  always_ff @(posedge sys_clk) begin
    if (do_push && !fifo.flush) begin
      store_mem[wr_ptr] <= fifo.push_data;
    end
  end

endmodule // seep_fifo

// ### rtl/seep_eeprom.sv
// Serial two-wire EEPROM slave: 2048 x 8 array, protect pin, power-on reset
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/100ps
module seep_eeprom #(
  parameter logic [3:0] TYPE_ID   = seep_pkg::TYPE_ID_DEFAULT,
  parameter int         WRITE_CNT = seep_pkg::WRITE_CYC
) (
  // Clock and reset
  input  wire logic                            sys_clk,
  input  wire logic                            sys_rst,
  // Supply detector, high once supply is above threshold
  input  wire logic                            power_ok_in,
  // Serial link pins
  input  wire logic                            scl_in,
  input  wire logic                            sda_in,
  output logic                                 sda_out,
  output logic                                 sda_oe,
  // Array protection
  input  wire logic                            write_protect_in,
  // Software register port
  input  wire logic [seep_pkg::REG_ADDR_W-1:0] reg_addr,
  input  wire logic [seep_pkg::REG_DATA_W-1:0] reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [seep_pkg::REG_DATA_W-1:0] reg_rdata,
  // Status
  output logic                                 write_busy
);
  import seep_pkg::*;

  // ==========================================================
  // Declarations
  logic                   rst_any;
  logic [2:0]             pin_sync;
  logic                   scl_s, sda_s, wp_s;
  logic                   scl_d, sda_d;
  logic                   scl_rise, scl_fall, bus_start, bus_stop;

  seep_state_t            state, next_state;
  seep_phase_t            phase, next_phase;
  logic [2:0]             bit_cnt, next_bit_cnt;
  logic [7:0]             shreg, next_shreg;
  logic                   byte_done, next_byte_done;
  logic                   rw, next_rw;
  logic                   data_slot, next_data_slot;
  logic                   mack, next_mack;
  logic                   next_sda_oe;
  logic [ARR_ADDR_W-1:0]  addr, next_addr;
  logic [ARR_ADDR_W-1:0]  wr_addr, next_wr_addr;
  logic [TIMER_W-1:0]     timer, next_timer;
  logic [REG_DATA_W-1:0]  ctrl, next_ctrl;
  logic [REG_DATA_W-1:0]  next_reg_rdata;
  logic                   next_write_busy;

  logic [7:0]             arr_mem [0:ARR_DEPTH-1];
  logic [7:0]             arr_q;
  logic                   arr_we;
  logic [ARR_ADDR_W-1:0]  arr_wa;
  logic [7:0]             arr_wd;

  seep_fifo_if #(.WIDTH(DATA_W)) wbuf ();

  // ==========================================================
  // Reset: host reset or supply under threshold
  assign rst_any = sys_rst | ~power_ok_in;

  // ==========================================================
  // Pin synchronisers and bus event detection
  seep_pin_sync #(
    .N        (3)
  ) u_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (rst_any),
    .async_in ({write_protect_in, sda_in, scl_in}),
    .sync_out (pin_sync)
  );

  assign scl_s = pin_sync[0];
  assign sda_s = pin_sync[1];
  assign wp_s  = pin_sync[2];

  // Previous pin levels for edges
  always_ff @(posedge sys_clk or posedge rst_any) begin
    if (rst_any) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Clock edges and start/stop conditions
  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

  // ==========================================================
  // Write-data buffer
  seep_fifo #(
    .WIDTH   (DATA_W),
    .DEPTH   (FIFO_DEPTH)
  ) u_wbuf (
    .sys_clk (sys_clk),
    .sys_rst (rst_any),
    .fifo    (wbuf.store)
  );

  // Array read port
  assign arr_q = arr_mem[addr];

  // ==========================================================
  // Serial interface next-state logic
  always_comb begin
    next_state      = state;
    next_phase      = phase;
    next_bit_cnt    = bit_cnt;
    next_shreg      = shreg;
    next_byte_done  = byte_done;
    next_rw         = rw;
    next_data_slot  = data_slot;
    next_mack       = mack;
    next_sda_oe     = sda_oe;
    next_addr       = addr;
    next_wr_addr    = wr_addr;
    next_timer      = timer;
    wbuf.push_valid = 1'b0;
    wbuf.push_data  = shreg;
    wbuf.pop_ready  = 1'b0;
    wbuf.flush      = 1'b0;
    arr_we          = 1'b0;
    arr_wa          = wr_addr;
    arr_wd          = wbuf.pop_data;

    if (state == SEEP_WRITE) begin
      // Busy: line released, bus ignored, buffer drained to array
      next_sda_oe    = 1'b0;
      wbuf.pop_ready = 1'b1;
      next_timer     = TIMER_W'(timer + 1'b1);
      if (wbuf.pop_valid) begin
        arr_we       = 1'b1;
        next_wr_addr = seep_page_inc(wr_addr);
      end else if (timer >= TIMER_W'(WRITE_CNT - 1)) begin
        next_state = SEEP_IDLE;
      end
    end else if (bus_start) begin
      // Start or repeated start: fresh select byte, drop pending data
      next_state     = SEEP_RX;
      next_phase     = SEEP_PH_SEL;
      next_bit_cnt   = '0;
      next_byte_done = 1'b0;
      next_data_slot = 1'b0;
      next_sda_oe    = 1'b0;
      wbuf.flush     = 1'b1;
    end else if (bus_stop) begin
      next_sda_oe = 1'b0;
      if (data_slot && wbuf.pop_valid) begin
        next_state = SEEP_WRITE;
        next_timer = '0;
      end else begin
        next_state = SEEP_IDLE;
        wbuf.flush = 1'b1;
      end
      next_data_slot = 1'b0;
    end else begin
      case (state)
        SEEP_RX: begin
          if (scl_rise) begin
            // Sample data on rising clock
            next_shreg     = {shreg[6:0], sda_s};
            next_bit_cnt   = 3'(bit_cnt + 1'b1);
            // Slot lasts through first high phase, where a stop lands
            next_data_slot = data_slot & (bit_cnt == 3'h0);
            next_byte_done = (bit_cnt == BIT_LAST);
          end else if (scl_fall && byte_done) begin
            next_byte_done = 1'b0;
            case (phase)
              SEEP_PH_SEL: begin
                if (shreg[SEL_TYPE_MSB:SEL_TYPE_LSB] == TYPE_ID
                    && ctrl[CTRL_EN_BIT]) begin
                  next_addr[ARR_ADDR_W-1:8] = shreg[SEL_HI_MSB:SEL_HI_LSB];
                  next_rw     = shreg[SEL_RW_BIT];
                  next_sda_oe = 1'b1;
                  next_state  = SEEP_ACK;
                end else begin
                  next_state = SEEP_WAIT;
                end
              end
              SEEP_PH_ADDR: begin
                // Address byte always acknowledged
                next_addr[7:0] = shreg;
                next_wr_addr   = {addr[ARR_ADDR_W-1:8], shreg};
                next_sda_oe    = 1'b1;
                next_state     = SEEP_ACK;
              end
              default: begin
                // Data byte: buffered only while unprotected and room left
                if (!wp_s && wbuf.push_ready) begin
                  wbuf.push_valid = 1'b1;
                  next_addr       = seep_page_inc(addr);
                  next_sda_oe     = 1'b1;
                end else begin
                  next_sda_oe = 1'b0;
                end
                next_state = SEEP_ACK;
              end
            endcase
          end
        end
        SEEP_ACK: begin
          if (scl_fall) begin
            next_sda_oe  = 1'b0;
            next_bit_cnt = '0;
            if (phase == SEEP_PH_SEL && rw) begin
              // Read: first byte out from current address
              next_shreg  = arr_q;
              next_addr   = ARR_ADDR_W'(addr + 1'b1);
              next_sda_oe = ~arr_q[7];
              next_phase  = SEEP_PH_DATA;
              next_state  = SEEP_TX;
            end else begin
              next_data_slot = (phase == SEEP_PH_DATA);
              next_phase     = (phase == SEEP_PH_SEL) ? SEEP_PH_ADDR : SEEP_PH_DATA;
              next_state     = SEEP_RX;
            end
          end
        end
        SEEP_TX: begin
          if (scl_fall) begin
            if (bit_cnt == BIT_LAST) begin
              next_sda_oe = 1'b0;
              next_state  = SEEP_RACK;
            end else begin
              // Shift next bit out on falling clock
              next_shreg   = {shreg[6:0], 1'b0};
              next_bit_cnt = 3'(bit_cnt + 1'b1);
              next_sda_oe  = ~shreg[6];
            end
          end
        end
        SEEP_RACK: begin
          if (scl_rise) begin
            next_mack = ~sda_s;
          end else if (scl_fall) begin
            if (mack) begin
              next_shreg   = arr_q;
              next_addr    = ARR_ADDR_W'(addr + 1'b1);
              next_sda_oe  = ~arr_q[7];
              next_bit_cnt = '0;
              next_state   = SEEP_TX;
            end else begin
              next_state = SEEP_WAIT;
            end
          end
        end
        default: begin
          // Idle or deselected: wait for start
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Serial interface registers; supply loss aborts everything
  always_ff @(posedge sys_clk or posedge rst_any) begin
    if (rst_any) begin
      state     <= SEEP_IDLE;
      phase     <= SEEP_PH_SEL;
      bit_cnt   <= '0;
      shreg     <= '0;
      byte_done <= 1'b0;
      rw        <= 1'b0;
      data_slot <= 1'b0;
      mack      <= 1'b0;
      sda_oe    <= 1'b0;
      addr      <= '0;
      wr_addr   <= '0;
      timer     <= '0;
    end else begin
      state     <= next_state;
      phase     <= next_phase;
      bit_cnt   <= next_bit_cnt;
      shreg     <= next_shreg;
      byte_done <= next_byte_done;
      rw        <= next_rw;
      data_slot <= next_data_slot;
      mack      <= next_mack;
      sda_oe    <= next_sda_oe;
      addr      <= next_addr;
      wr_addr   <= next_wr_addr;
      timer     <= next_timer;
    end
  end

  // Array write port, only reached from the write cycle
  always_ff @(posedge sys_clk) begin
    if (arr_we) begin
      arr_mem[arr_wa] <= arr_wd;
    end
  end

  // ==========================================================
  // Software registers and status outputs
  always_comb begin
    next_ctrl       = ctrl;
    next_reg_rdata  = '0;
    next_write_busy = (next_state == SEEP_WRITE);
    if (reg_wr && reg_addr == REG_CTRL_OFS) begin
      next_ctrl = reg_wdata;
    end
    if (reg_rd) begin
      if (reg_addr == REG_STATUS_OFS) begin
        next_reg_rdata                = {5'h0, state};
        next_reg_rdata[STAT_BUSY_BIT] = write_busy;
        next_reg_rdata[STAT_WP_BIT]   = wp_s;
      end else if (reg_addr == REG_CTRL_OFS) begin
        next_reg_rdata = ctrl;
      end else begin
        next_reg_rdata = '0;
      end
    end
  end

  // Register outputs; data pin level is always low when driven
  always_ff @(posedge sys_clk or posedge rst_any) begin
    if (rst_any) begin
      ctrl       <= CTRL_RESET;
      reg_rdata  <= '0;
      write_busy <= 1'b0;
      sda_out    <= 1'b0;
    end else begin
      ctrl       <= next_ctrl;
      reg_rdata  <= next_reg_rdata;
      write_busy <= next_write_busy;
      sda_out    <= 1'b0;
    end
  end

endmodule // seep_eeprom

// ### test/seep_eeprom_asserts.sv
// Concurrent checks on the serial EEPROM slave ports
`timescale 1ns/100ps
module seep_eeprom_asserts #(
  parameter int WRITE_CNT = 50
) (
  // Clock and reset
  input wire logic                           sys_clk,
  input wire logic                           sys_rst,
  // Supply, link and protect pins
  input wire logic                           power_ok_in,
  input wire logic                           scl_in,
  input wire logic                           sda_in,
  input wire logic                           sda_out,
  input wire logic                           sda_oe,
  input wire logic                           write_protect_in,
  // Register port and status
  input wire logic [seep_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [seep_pkg::REG_DATA_W-1:0] reg_wdata,
  input wire logic                           reg_wr,
  input wire logic                           reg_rd,
  input wire logic [seep_pkg::REG_DATA_W-1:0] reg_rdata,
  input wire logic                           write_busy
);
  import seep_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // Length of the running write cycle
  logic [15:0] busy_cnt;
  logic [15:0] next_busy_cnt;
  always_comb next_busy_cnt = write_busy ? busy_cnt + 16'h1 : 16'h0;
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst) busy_cnt <= 16'h0;
    else busy_cnt <= next_busy_cnt;

  // ==========================================================
  // Properties
  property p_open_drain; sda_out == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("data line driven high");
  property p_por_quiet; !power_ok_in |-> !sda_oe; endproperty
  a_por_quiet: assert property (p_por_quiet) else $error("drive without supply");
  property p_por_idle; !power_ok_in |-> !write_busy; endproperty
  a_por_idle: assert property (p_por_idle) else $error("busy without supply");
  property p_standby; $rose(power_ok_in) |-> !sda_oe [*4]; endproperty
  a_standby: assert property (p_standby) else $error("drive after power up");
  property p_busy_quiet; write_busy |-> !sda_oe; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("drive while writing");
  property p_busy_len;
    disable iff (sys_rst || !power_ok_in) $fell(write_busy) |-> busy_cnt == 16'(WRITE_CNT);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_write_on_stop; $rose(write_busy) |-> scl_in && sda_in; endproperty
  a_write_on_stop: assert property (p_write_on_stop) else $error("write not after stop");
  property p_shift_low;
    disable iff (sys_rst || !power_ok_in) $changed(sda_oe) |-> !scl_in;
  endproperty
  a_shift_low: assert property (p_shift_low) else $error("data moved with clock high");

  // Main scenarios reached
  c_write: cover property ($rose(write_busy));
  c_ack: cover property ($rose(sda_oe));
  c_por: cover property ($fell(power_ok_in));
endmodule // seep_eeprom_asserts

bind seep_eeprom seep_eeprom_asserts #(.WRITE_CNT(WRITE_CNT)) i_asserts (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .power_ok_in(power_ok_in),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .write_protect_in(write_protect_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .write_busy(write_busy)
);

// ### test/seep_i2c_master.sv
// Two-wire bus master model driving the EEPROM link
`timescale 1ns/100ps
module seep_i2c_master (
  // Clock
  input  wire logic       sys_clk,
  // Resolved data wire
  input  wire logic       sda_w,
  // Driven link pins
  output logic            scl,
  output logic            sda_low,
  // Result of each byte or acknowledge
  output logic            res_v,
  output logic [7:0]      res_d
);
  // ==========================================================
  // Quarter of a 160 ns link period
  localparam int Q = 5;
  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    res_v = 1'b0;
    res_d = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One pulse; data moves only while clock is low
  task automatic bit_io(input logic b, output logic v);
    scl <= 1'b0;
    tick(Q);
    sda_low <= !b;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    #1 v = sda_w;
    tick(Q);
  endtask
  // Start or repeated start: data falls with clock high
  task automatic start();
    scl <= 1'b0;
    tick(Q);
    sda_low <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_low <= 1'b1;
    tick(Q);
  endtask
  // Stop: data rises with clock high, bus then idles
  task automatic stop();
    scl <= 1'b0;
    tick(Q);
    sda_low <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_low <= 1'b0;
    tick(2 * Q);
  endtask
  // Hand a result to the bench for one cycle
  task automatic report(input logic [7:0] d);
    res_d <= d;
    res_v <= 1'b1;
    tick(1);
    res_v <= 1'b0;
  endtask
  // Send a byte MSB first, then sample the acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) bit_io(d[i], v);
    bit_io(1'b1, ack);
    report({7'h0, ack});
  endtask
  // Take a byte MSB first, then acknowledge it or not
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, v);
      d[i] = v;
    end
    bit_io(!mack, v);
    report(d);
  endtask
endmodule // seep_i2c_master

// ### test/seep_eeprom_tb.sv
// Self-checking bench for the serial EEPROM slave
`timescale 1ns/100ps
module seep_eeprom_tb;
  import seep_pkg::*;
  // ==========================================================
  // Signals
  localparam int WCNT = 400;
  logic       sys_clk;
  logic       sys_rst;
  logic       power_ok_in;
  logic       write_protect_in;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       sda_out;
  logic       sda_oe;
  logic       write_busy;
  logic       scl;
  logic       m_low;
  logic       sda_w;
  logic       res_v;
  logic [7:0] res_d;
  logic       rd_d;
  logic       s;
  logic [7:0] s8;
  logic [7:0] exp_q[$];
  logic [7:0] mem[8];
  int         err_count;
  int         total_checks;
  int         seed;

  // Open-drain wire with pull-up
  assign sda_w = ((sda_oe && !sda_out) || m_low) ? 1'b0 : 1'b1;

  seep_eeprom #(.WRITE_CNT(WCNT)) i_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .power_ok_in(power_ok_in),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .write_protect_in(write_protect_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .write_busy(write_busy));
  seep_i2c_master i_mst (.sys_clk(sys_clk), .sda_w(sda_w), .scl(scl),
    .sda_low(m_low), .res_v(res_v), .res_d(res_d));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Checking
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Result watcher takes the oldest note
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    if (res_v || rd_d) begin
      if (exp_q.size() == 0) chk(8'h01, 8'h00, "result without note");
      else chk(res_v ? res_d : reg_rdata, exp_q.pop_front(), "result");
    end
  end
  task automatic stop_test();
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Drivers
  task automatic rrd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rwr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wb(input logic [7:0] d, input logic ack);
    exp_q.push_back({7'h0, ack});
    i_mst.wbyte(d, s);
  endtask
  task automatic sel(input logic [3:0] t, input logic rw, input logic ack);
    i_mst.start();
    wb({t, 3'h5, rw}, ack);
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (write_busy !== lvl && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    chk({7'h0, write_busy}, {7'h0, lvl}, "write busy");
  endtask
  // Random read of the eight stored bytes
  task automatic rd_page();
    sel(TYPE_ID_DEFAULT, 1'b0, 1'b0);
    wb(8'ha0, 1'b0);
    sel(TYPE_ID_DEFAULT, 1'b1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      exp_q.push_back(mem[i]);
      i_mst.rbyte(i < 7, s8);
    end
    i_mst.stop();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    seed = 2;
    err_count = 0;
    total_checks = 0;
    rd_d = 1'b0;
    sys_rst = 1'b1;
    power_ok_in = 1'b1;
    write_protect_in = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rrd(REG_STATUS_OFS, 8'h00);
    rrd(REG_CTRL_OFS, CTRL_RESET);
    rwr(4'hf, 8'h00);
    rrd(4'hf, 8'h00);
    rrd(REG_CTRL_OFS, CTRL_RESET);
    // Nine bytes into an eight-word buffer
    sel(TYPE_ID_DEFAULT, 1'b0, 1'b0);
    wb(8'ha0, 1'b0);
    for (int i = 0; i < 9; i++) begin
      if (i < 8) mem[i] = 8'($random(seed));
      wb(i < 8 ? mem[i] : 8'h3c, i == 8);
    end
    i_mst.stop();
    wait_busy(1'b1);
    sel(TYPE_ID_DEFAULT, 1'b0, 1'b1);
    i_mst.stop();
    wait_busy(1'b0);
    rd_page();
    // Protected write leaves the array alone
    write_protect_in <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rrd(REG_STATUS_OFS, 8'h10);
    sel(TYPE_ID_DEFAULT, 1'b0, 1'b0);
    wb(8'ha0, 1'b0);
    wb(~mem[0], 1'b1);
    i_mst.stop();
    repeat (WCNT + 20) @(posedge sys_clk);
    write_protect_in <= 1'b0;
    rd_page();
    // Stop after the address byte starts nothing
    sel(TYPE_ID_DEFAULT, 1'b0, 1'b0);
    wb(8'ha3, 1'b0);
    i_mst.stop();
    repeat (10) @(posedge sys_clk);
    chk({7'h0, write_busy}, 8'h00, "stop after address");
    // Data dropped by a repeated start, so the stop writes nothing
    sel(TYPE_ID_DEFAULT, 1'b0, 1'b0);
    wb(8'ha3, 1'b0);
    wb(8'h5a, 1'b0);
    i_mst.start();
    i_mst.stop();
    repeat (10) @(posedge sys_clk);
    chk({7'h0, write_busy}, 8'h00, "stop after start");
    sel(TYPE_ID_DEFAULT ^ 4'h3, 1'b0, 1'b1);
    i_mst.stop();
    rwr(REG_CTRL_OFS, 8'h00);
    sel(TYPE_ID_DEFAULT, 1'b0, 1'b1);
    i_mst.stop();
    rwr(REG_CTRL_OFS, CTRL_RESET);
    // Supply loss, in standby and in mid-transfer
    power_ok_in <= 1'b0;
    sel(TYPE_ID_DEFAULT, 1'b0, 1'b1);
    i_mst.stop();
    power_ok_in <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sel(TYPE_ID_DEFAULT, 1'b0, 1'b0);
    wb(8'ha0, 1'b0);
    power_ok_in <= 1'b0;
    repeat (2) @(posedge sys_clk);
    power_ok_in <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sel(TYPE_ID_DEFAULT, 1'b0, 1'b0);
    i_mst.stop();
    rrd(REG_STATUS_OFS, 8'h00);
    repeat (4) @(posedge sys_clk);
    chk(8'(exp_q.size()), 8'h00, "notes left");
    stop_test();
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule // seep_eeprom_tb
